// ---- pkg/plf_pkg.sv ----
// Constants for the PWM loopback fault report block
// Functional notes
// - Twelve duty-fault flags, one per channel: 0 means the channel passed, 1 means it failed.
// - The duty-fault summary bit in fault_type_low is set while any channel flag is 1.
// - The fault_report_n pin is pulled low while the summary bit and its mask bit are both set.
// - Host writes never clear the channel flags; only a later verification run clears them.
// - The summary bit clears by itself once every channel flag is back at 0.
// - Measured duty of the selected channel: bits 9:2 in the high byte, bits 1:0 in the low byte.
// - An 8-bit read-only identification register always returns a fixed code.
// - Writes to the identification register are ignored and change nothing.
// - A channel is flagged when measured duty differs from programmed duty by more than tolerance.
// - A 4-bit channel select picks channel 1 to 12 with values 0 to 11, one channel at a time.
package plf_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FAULT_TYPE_LOW = 8'h94;
  localparam logic [7:0] IDX_FAULT_MASK_LOW = 8'h96;
  localparam logic [7:0] IDX_VERIFY_CTRL = 8'hc1;
  localparam logic [7:0] IDX_VERIFY_CFG = 8'hc2;
  localparam logic [7:0] IDX_DUTY_FAULT_LOW = 8'hc3;
  localparam logic [7:0] IDX_DUTY_FAULT_HIGH = 8'hc4;
  localparam logic [7:0] IDX_MEASURED_DUTY_HIGH = 8'hc5;
  localparam logic [7:0] IDX_MEASURED_DUTY_LOW = 8'hc6;
  localparam logic [7:0] IDX_CHIP_IDENTITY_CODE = 8'hc7;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hd0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd1;

  // Field positions
  localparam int LOOP_FAULT_SUMMARY_BIT = 0;
  localparam int LOOP_FAULT_REPORT_MASK_BIT = 0;
  localparam int CHANNEL_SELECT_LSB = 4;
  localparam int IRQ_NEW_FAULT_BIT = 0;
  localparam int IRQ_RESULT_BIT = 1;
  localparam int IRQ_WIDTH = 2;

  // Reset values
  localparam logic [6:0] TOLERANCE_RST = 7'h02;
  localparam logic [3:0] CHANNEL_SELECT_RST = 4'h0;
  localparam logic MASK_RST = 1'b1;
  localparam logic [9:0] MEASURED_DUTY_RST = 10'h000;

  // Identity code; value is arbitrary
  localparam logic [7:0] CHIP_IDENTITY_VALUE = 8'h5c;

endpackage

// ---- rtl/plf_duty_cmp.sv ----
// Deviation comparator between measured and programmed duty
`timescale 1ns/1ns
`default_nettype none
module plf_duty_cmp #(
  parameter int DW = 10,
  parameter int TW = 7
) (
  // Operands
  input wire logic [DW-1:0] i_measured,
  input wire logic [DW-1:0] i_programmed,
  input wire logic [TW-1:0] i_tolerance,
  // Result
  output logic o_exceeds
);

  logic [DW-1:0] diff;

  always_comb
  begin
    if (i_measured >= i_programmed)
    begin
      diff = i_measured - i_programmed;
    end
    else
    begin
      diff = i_programmed - i_measured;
    end
    o_exceeds = ({1'b0, diff} > {{(DW + 1 - TW){1'b0}}, i_tolerance});
  end

endmodule // plf_duty_cmp
`default_nettype wire

// ---- rtl/plf_irq.sv ----
// Sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ns
`default_nettype none
module plf_irq #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Events and software access
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  input wire logic i_mask_wr,
  input wire logic [W-1:0] i_mask_wdata,
  // State
  output logic [W-1:0] o_status,
  output logic [W-1:0] o_mask,
  output logic o_irq
);

  logic [W-1:0] status_r;
  logic [W-1:0] mask_r;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      status_r <= '0;
    end
    else
    begin
      status_r <= (status_r & ~i_clr) | i_set;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      mask_r <= '0;
    end
    else if (i_mask_wr)
    begin
      mask_r <= i_mask_wdata;
    end
  end

  assign o_status = status_r;
  assign o_mask = mask_r;
  assign o_irq = |(status_r & mask_r);

endmodule // plf_irq
`default_nettype wire

// ---- rtl/plf_report.sv ----
// PWM loopback fault report: flags, summary pin, measured duty, identity, APB slave
`timescale 1ns/1ns
`default_nettype none
module plf_report #(
  parameter int NCH = 12,
  parameter int DW = 10,
  parameter int TW = 7
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Results from the measurement engine
  input wire logic i_meas_valid,
  input wire logic [3:0] i_meas_chan,
  input wire logic [DW-1:0] i_meas_duty,
  input wire logic [NCH*DW-1:0] i_prog_duty,
  // Settings towards the measurement engine
  output logic [3:0] o_verify_channel_select,
  output logic [TW-1:0] o_tolerance,
  // Open-drain fault pin
  output logic o_fault_report_n,
  output logic o_fault_report_oe,
  // Interrupt
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [NCH-1:0] duty_fault_r;
  logic [NCH-1:0] fault_set;
  logic [3:0] chan_sel_r;
  logic [TW-1:0] tolerance_r;
  logic fault_mask_r;
  logic [DW-1:0] measured_duty_r;
  logic loop_fault_summary;
  logic [DW-1:0] prog_sel;
  logic exceeds;
  logic chan_valid;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [7:0] idx;
  logic addr_ok;
  logic setup;
  logic access_wr;
  logic lane0_wr;
  logic hit_known;
  logic [31:0] rdata_nxt;
  logic [plf_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [plf_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic [plf_pkg::IRQ_WIDTH-1:0] irq_set;
  logic [plf_pkg::IRQ_WIDTH-1:0] irq_clr;
  logic irq_mask_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign idx = i_paddr[9:2];
  assign addr_ok = (i_paddr[11:10] == 2'h0) && (i_paddr[1:0] == 2'h0);
  assign setup = i_psel && !i_penable;
  assign access_wr = i_psel && i_penable && i_pwrite && addr_ok;
  assign lane0_wr = access_wr && i_pstrb[0];

  always_comb
  begin
    unique case (idx)
      plf_pkg::IDX_FAULT_TYPE_LOW,
      plf_pkg::IDX_FAULT_MASK_LOW,
      plf_pkg::IDX_VERIFY_CTRL,
      plf_pkg::IDX_VERIFY_CFG,
      plf_pkg::IDX_DUTY_FAULT_LOW,
      plf_pkg::IDX_DUTY_FAULT_HIGH,
      plf_pkg::IDX_MEASURED_DUTY_HIGH,
      plf_pkg::IDX_MEASURED_DUTY_LOW,
      plf_pkg::IDX_CHIP_IDENTITY_CODE,
      plf_pkg::IDX_IRQ_STATUS,
      plf_pkg::IDX_IRQ_MASK:
      begin
        hit_known = addr_ok;
      end
      default:
      begin
        hit_known = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Channel select; codes 12 to 15 select nothing
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      chan_sel_r <= plf_pkg::CHANNEL_SELECT_RST;
    end
    else if (lane0_wr && idx == plf_pkg::IDX_VERIFY_CTRL)
    begin
      chan_sel_r <= i_pwdata[plf_pkg::CHANNEL_SELECT_LSB +: 4];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      tolerance_r <= plf_pkg::TOLERANCE_RST;
    end
    else if (lane0_wr && idx == plf_pkg::IDX_VERIFY_CFG)
    begin
      tolerance_r <= i_pwdata[TW-1:0];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      fault_mask_r <= plf_pkg::MASK_RST;
    end
    else if (lane0_wr && idx == plf_pkg::IDX_FAULT_MASK_LOW)
    begin
      fault_mask_r <= i_pwdata[plf_pkg::LOOP_FAULT_REPORT_MASK_BIT];
    end
  end

  assign o_verify_channel_select = chan_sel_r;
  assign o_tolerance = tolerance_r;

  ////////////////////////////////////////////////////////////////////////////
  // Verification result

  assign chan_valid = (i_meas_chan < 4'(NCH));

  always_comb
  begin
    prog_sel = '0;
    for (int c = 0; c < NCH; c++)
    begin
      if (i_meas_chan == 4'(c))
      begin
        prog_sel = i_prog_duty[c*DW +: DW];
      end
    end
  end

  plf_duty_cmp #(
    .DW(DW),
    .TW(TW)
  ) u_cmp (
    .i_measured(i_meas_duty),
    .i_programmed(prog_sel),
    .i_tolerance(tolerance_r),
    .o_exceeds(exceeds)
  );

  // One flag per channel, changed only by a verification result
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_flag
      always_ff @(posedge i_mclk)
      begin
        if (i_sys_rst)
        begin
          duty_fault_r[g] <= 1'b0;
        end
        else if (i_meas_valid && chan_valid && i_meas_chan == 4'(g))
        begin
          duty_fault_r[g] <= exceeds;
        end
      end
      assign fault_set[g] = i_meas_valid && chan_valid && i_meas_chan == 4'(g)
                            && exceeds && !duty_fault_r[g];
    end
  endgenerate

  // Summary follows the flags, so it clears by itself
  assign loop_fault_summary = |duty_fault_r;

  // Open-drain pin: pulled low only while the summary is reported
  assign o_fault_report_oe = loop_fault_summary && fault_mask_r;
  assign o_fault_report_n = 1'b0;

  // Duty of the selected channel, as last measured
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      measured_duty_r <= plf_pkg::MEASURED_DUTY_RST;
    end
    else if (i_meas_valid && chan_valid && i_meas_chan == chan_sel_r)
    begin
      measured_duty_r <= i_meas_duty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign irq_set[plf_pkg::IRQ_NEW_FAULT_BIT] = |fault_set;
  assign irq_set[plf_pkg::IRQ_RESULT_BIT] = i_meas_valid && chan_valid;
  assign irq_clr = (lane0_wr && idx == plf_pkg::IDX_IRQ_STATUS) ?
                   i_pwdata[plf_pkg::IRQ_WIDTH-1:0] : '0;
  assign irq_mask_wr = lane0_wr && idx == plf_pkg::IDX_IRQ_MASK;

  plf_irq #(
    .W(plf_pkg::IRQ_WIDTH)
  ) u_irq (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_set(irq_set),
    .i_clr(irq_clr),
    .i_mask_wr(irq_mask_wr),
    .i_mask_wdata(i_pwdata[plf_pkg::IRQ_WIDTH-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Read-only registers have no write path at all
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (idx)
      plf_pkg::IDX_FAULT_TYPE_LOW:
      begin
        rdata_nxt[plf_pkg::LOOP_FAULT_SUMMARY_BIT] = loop_fault_summary;
      end
      plf_pkg::IDX_FAULT_MASK_LOW:
      begin
        rdata_nxt[plf_pkg::LOOP_FAULT_REPORT_MASK_BIT] = fault_mask_r;
      end
      plf_pkg::IDX_VERIFY_CTRL:
      begin
        rdata_nxt[plf_pkg::CHANNEL_SELECT_LSB +: 4] = chan_sel_r;
      end
      plf_pkg::IDX_VERIFY_CFG:
      begin
        rdata_nxt[TW-1:0] = tolerance_r;
      end
      plf_pkg::IDX_DUTY_FAULT_LOW:
      begin
        rdata_nxt[7:0] = duty_fault_r[7:0];
      end
      plf_pkg::IDX_DUTY_FAULT_HIGH:
      begin
        rdata_nxt[NCH-9:0] = duty_fault_r[NCH-1:8];
      end
      plf_pkg::IDX_MEASURED_DUTY_HIGH:
      begin
        rdata_nxt[7:0] = measured_duty_r[9:2];
      end
      plf_pkg::IDX_MEASURED_DUTY_LOW:
      begin
        rdata_nxt[1:0] = measured_duty_r[1:0];
      end
      plf_pkg::IDX_CHIP_IDENTITY_CODE:
      begin
        rdata_nxt[7:0] = plf_pkg::CHIP_IDENTITY_VALUE;
      end
      plf_pkg::IDX_IRQ_STATUS:
      begin
        rdata_nxt[plf_pkg::IRQ_WIDTH-1:0] = irq_status;
      end
      plf_pkg::IDX_IRQ_MASK:
      begin
        rdata_nxt[plf_pkg::IRQ_WIDTH-1:0] = irq_mask;
      end
      default:
      begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
    if (!addr_ok)
    begin
      rdata_nxt = 32'h0000_0000;
    end
  end

  // Captured in the setup cycle, presented through the access cycle
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (setup)
    begin
      prdata_r <= i_pwrite ? 32'h0000_0000 : rdata_nxt;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_r <= !hit_known;
    end
  end

  assign o_prdata = prdata_r;
  assign o_pslverr = pslverr_r && i_psel && i_penable;
  assign o_pready = 1'b1;

endmodule // plf_report
`default_nettype wire

// ---- dv/plf_report_properties.sv ----
// Port assertions for the loopback fault report block
`timescale 1ns/1ns
`default_nettype none
module plf_report_properties (
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_meas_valid,
  input wire logic [3:0] o_verify_channel_select,
  input wire logic [6:0] o_tolerance,
  input wire logic o_fault_report_n,
  input wire logic o_fault_report_oe
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  wire logic acc_w = i_psel && i_penable && i_pwrite && i_pstrb[0];
  sequence s_rd(logic [11:0] a);
    i_psel && !i_penable && !i_pwrite && i_paddr == a;
  endsequence
  property p_id;
    s_rd(12'h31c) |=> o_prdata == {24'h0, plf_pkg::CHIP_IDENTITY_VALUE};
  endproperty
  a_id: assert property (p_id) else $error("identity read wrong");
  property p_dh;
    s_rd(12'h314) |=> o_prdata[31:8] == 24'h0;
  endproperty
  a_dh: assert property (p_dh) else $error("duty high upper bits set");
  property p_dl;
    s_rd(12'h318) |=> o_prdata[31:2] == 30'h0;
  endproperty
  a_dl: assert property (p_dl) else $error("duty low reserved bits set");
  property p_iderr;
    s_rd(12'h31c) ##1 i_penable |-> !o_pslverr;
  endproperty
  a_iderr: assert property (p_iderr) else $error("identity access errored");
  property p_sel;
    $changed(o_verify_channel_select) |-> $past(acc_w && i_paddr == 12'h304);
  endproperty
  a_sel: assert property (p_sel) else $error("select moved without write");
  property p_tol;
    $changed(o_tolerance) |-> $past(acc_w && i_paddr == 12'h308);
  endproperty
  a_tol: assert property (p_tol) else $error("tolerance moved without write");
  property p_rise;
    $rose(o_fault_report_oe) |-> $past(i_meas_valid || (acc_w && i_paddr == 12'h258));
  endproperty
  a_rise: assert property (p_rise) else $error("pin asserted without cause");
  property p_fall;
    $fell(o_fault_report_oe) |-> $past(i_meas_valid || (acc_w && i_paddr == 12'h258));
  endproperty
  a_fall: assert property (p_fall) else $error("pin released without cause");
  property p_pin;
    o_fault_report_n == 1'b0;
  endproperty
  a_pin: assert property (p_pin) else $error("pin value not low");
  property p_sumpin;
    s_rd(12'h250) ##1 (i_penable && !o_prdata[0] && !$past(i_meas_valid)) |->
      !o_fault_report_oe;
  endproperty
  a_sumpin: assert property (p_sumpin) else $error("pin pulled without summary");
endmodule // plf_report_properties
`default_nettype wire

// ---- dv/plf_report_tb.sv ----
// Self-checking bench for the loopback fault report block
`timescale 1ns/1ns
`default_nettype none
bind plf_report plf_report_properties i_plf_report_properties (.i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_meas_valid(i_meas_valid), .o_verify_channel_select(o_verify_channel_select),
  .o_tolerance(o_tolerance), .o_fault_report_n(o_fault_report_n),
  .o_fault_report_oe(o_fault_report_oe));
module plf_report_tb;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, mv = 1'b0, mk, rdy, serr, oen, oe, irq, er;
  logic [11:0] padr = 12'h0, flg;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [3:0] pst = 4'h0, mc = 4'h0, osel, sel, ch;
  logic [3:0] stb = 4'h1;
  logic [9:0] md = 10'h0, mdv, dv;
  logic [119:0] prog = 120'h0;
  logic [6:0] otol, tol;
  logic [11:0] ro [6] = '{12'h30c, 12'h310, 12'h250, 12'h31c, 12'h314, 12'h318};
  int err_total = 0, checks_done = 0;
  always #2 i_mclk = ~i_mclk;
  plf_report i_plf_report (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .i_pstrb(pst),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr), .i_meas_valid(mv), .i_meas_chan(mc),
    .i_meas_duty(md), .i_prog_duty(prog), .o_verify_channel_select(osel),
    .o_tolerance(otol), .o_fault_report_n(oen), .o_fault_report_oe(oe), .o_irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic int dev(input logic [9:0] a, input logic [9:0] b);
    return (a > b) ? a - b : b - a;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    pst <= stb;
    @(posedge i_mclk);
    pen <= 1'b1;
    // The wait ends once rdy is 1; only the watchdog ends a wait that never completes
    do
    begin
      @(posedge i_mclk);
    end
    while (rdy !== 1'b1);
    rd = prd;
    er = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(er, 1'b0);
  endtask
  task automatic meas(input logic [3:0] c, input logic [9:0] d);
    mv <= 1'b1;
    mc <= c;
    md <= d;
    @(posedge i_mclk);
    mv <= 1'b0;
    @(posedge i_mclk);
    if (c < 4'd12)
    begin
      flg[c] = dev(d, prog[int'(c)*10 +: 10]) > int'(tol);
      if (c == sel)
        mdv = d;
    end
  endtask
  task automatic chk_all();
    rdc(12'h30c, {24'h0, flg[7:0]});
    rdc(12'h310, {28'h0, flg[11:8]});
    rdc(12'h250, {31'h0, |flg});
    chk(oe, |flg & mk);
    chk(oen, 1'b0);
    rdc(12'h314, {24'h0, mdv[9:2]});
    rdc(12'h318, {30'h0, mdv[1:0]});
    chk(otol, tol);
    chk(osel, sel);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rd = $urandom(32'hb5d8c0b1);
    flg = 12'h0;
    mdv = 10'h0;
    sel = 4'h0;
    tol = 7'h02;
    mk = 1'b1;
    for (int c = 0; c < 12; c++)
      prog[c*10 +: 10] <= 10'($urandom);
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    rdc(12'h31c, {24'h0, plf_pkg::CHIP_IDENTITY_VALUE});
    rdc(12'h258, 32'h1);
    chk_all();
    apb(1'b0, 12'h3fc, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, 12'h31d, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, 12'h71c, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    stb = 4'h0;
    apb(1'b1, 12'h308, 32'h7f);
    stb = 4'h1;
    chk(otol, tol);
    $display("Test reset and decode done");
    for (int i = 0; i < 40; i++)
    begin
      sel = 4'($urandom_range(11));
      tol = 7'($urandom);
      apb(1'b1, 12'h304, {24'h0, sel, 4'h0});
      apb(1'b1, 12'h308, {25'h0, tol});
      ch = (i < 4) ? sel : 4'($urandom_range(15));
      dv = (i < 4) ? prog[int'(ch)*10 +: 10] + tol + 10'(i & 1) : 10'($urandom);
      meas(ch, dv);
      chk_all();
    end
    $display("Test random results done");
    meas(4'd0, prog[9:0] ^ 10'h200);
    for (int v = 0; v < 2; v++)
      foreach (ro[k])
        apb(1'b1, ro[k], v ? 32'hff : 32'h0);
    chk_all();
    rdc(12'h31c, {24'h0, plf_pkg::CHIP_IDENTITY_VALUE});
    mk = 1'b0;
    apb(1'b1, 12'h258, 32'h0);
    chk_all();
    mk = 1'b1;
    apb(1'b1, 12'h258, 32'h1);
    for (int c = 0; c < 12; c++)
      meas(4'(c), prog[c*10 +: 10]);
    chk_all();
    $display("Test read-only and clear done");
    apb(1'b1, 12'h344, 32'h3);
    apb(1'b1, 12'h340, 32'h3);
    rdc(12'h340, 32'h0);
    chk(irq, 1'b0);
    meas(4'd0, prog[9:0] ^ 10'h200);
    rdc(12'h340, 32'h3);
    chk(irq, 1'b1);
    apb(1'b1, 12'h344, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, 12'h340, 32'h1);
    rdc(12'h340, 32'h2);
    $display("Test interrupt done");
    stop_test();
  end
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule // plf_report_tb
`default_nettype wire
